//--- logic/baud_frame_pkg.sv
/*
  Holds the register map, field positions, reset values and shared types of the
  serial port baud and frame configuration block.
  Assumes a byte-wide register port with byte offsets.
*/
package baud_frame_pkg;

  localparam int          DIVISOR_W        = 13;
  localparam int          OVERSAMPLE       = 16;
  localparam int          DIV_HIGH_W       = 5;

  localparam logic [7:0]  OFS_DIV_HIGH     = 8'h40;
  localparam logic [7:0]  OFS_DIV_LOW      = 8'h41;
  localparam logic [7:0]  OFS_FRAME_CTRL   = 8'h42;

  localparam logic [7:0]  DIV_HIGH_RESET   = 8'h00;
  localparam logic [7:0]  DIV_LOW_RESET    = 8'h04;
  localparam logic [7:0]  FRAME_CTRL_RESET = 8'h00;

  // High divisor register fields
  localparam int          HI_BREAK_IE_BIT  = 7;
  localparam int          HI_EDGE_IE_BIT   = 6;
  localparam logic [7:0]  HI_WRITE_MASK    = 8'hDF;

  // Frame control fields
  localparam int          FC_LOOP_BIT      = 7;
  localparam int          FC_RECEIVE_SOURCE_SELECT_BIT      = 5;
  localparam int          FC_NINE_BIT      = 4;
  localparam int          FC_IDLE_BIT      = 2;
  localparam int          FC_PAR_ON_BIT    = 1;
  localparam int          FC_PAR_ODD_BIT   = 0;
  localparam logic [7:0]  FC_WRITE_MASK    = 8'hB7;

  localparam logic [3:0]  FRAME_BITS_EIGHT = 4'hA;
  localparam logic [3:0]  FRAME_BITS_NINE  = 4'hB;

  typedef enum logic [1:0] {
    LINK_NORMAL      = 2'b00,
    LINK_LOOPBACK    = 2'b01,
    LINK_SINGLE_WIRE = 2'b10
  } link_mode_e;

  typedef struct packed {
    logic       nine_bit_frame;
    logic       idle_count_after_stop;
    logic       parity_on;
    logic       parity_odd_select;
    logic [3:0] frame_bits;
  } frame_cfg_s;

endpackage : baud_frame_pkg

//--- logic/baud_tick_gen.sv
/*
  Modulo divider that makes the oversampling tick and the bit-rate tick.
  Assumes one system clock; the divisor and enable are steady registers.
*/
`timescale 1ns/1ns
module baud_tick_gen
  import baud_frame_pkg::*;
#(
  parameter int DIV_W = DIVISOR_W,
  parameter int OVS   = OVERSAMPLE
) (
  input  wire logic             clk_sys,     // System clock
  input  wire logic             resetn,      // Asynchronous reset, active low
  input  wire logic             enable,      // Generator allowed to run
  input  wire logic [DIV_W-1:0] divisor,     // Working divisor
  output logic                  sample_tick, // One pulse per oversample period
  output logic                  bit_tick     // One pulse per bit time
);

  localparam int OVS_W = $clog2(OVS);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] div_last_q;
  logic [OVS_W-1:0] ovs_q;
  logic             run;
  logic             wrap;

  assign run  = enable && (divisor != '0);
  assign wrap = (cnt_q == divisor - DIV_W'(1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_last_q <= '0;
    end else begin
      div_last_q <= divisor;
    end
  end

  // Counter clears when stopped or when the divisor changes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (!run || (div_last_q != divisor)) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovs_q       <= '0;
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else if (!run || (div_last_q != divisor)) begin
      ovs_q       <= '0;
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else begin
      sample_tick <= wrap;
      bit_tick    <= wrap && (ovs_q == OVS_W'(OVS - 1));
      if (wrap) begin
        ovs_q <= ovs_q + OVS_W'(1);
      end
    end
  end

endmodule : baud_tick_gen

//--- logic/baud_frame_config.sv
/*
  Baud divisor, frame format, parity and pin routing of an asynchronous serial
  port, reached over a byte-wide register port.
  Assumes the transmit and receive shifters, the second control register and
  the break and edge flags live outside; all inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ns
// Summary of operation
// - Divisor high write is buffered; becomes working value when low part written.
// - Generator stays off after reset until receiver or transmitter enabled.
// - Divisor zero stops the baud generator completely.
// - Divisor 1 to 8191 gives bit rate of clock over sixteen times divisor.
// - High register bit 7 enables break-detect interrupt request.
// - High register bit 6 enables receive-edge interrupt request.
// - Loop select clear: full duplex on separate receive and transmit pins.
// - Loop select set: receiver fed internally or from transmit pin, receive pin unused.
// - Receive-source select is ignored unless loop select is set.
// - Loop set, source clear: internal loop-back, receive pin unused.
// - Loop and source set: single wire, transmit pin feeds receiver too.
// - Length select clear: start, eight data bits LSB first, stop.
// - Length select set: start, eight data bits, ninth bit, stop.
// - Idle count of 10 or 11 bits starts after start or stop bit.
// - Parity enable: hardware makes and checks parity in the top data bit.
// - Parity type clear is even, set is odd, counted over all ones.
// - Transmitter enable drives the transmit pin as an output.
// - In single wire, direction bit decides drive or receive on transmit line.
module baud_frame_config
  import baud_frame_pkg::*;
(
  input  wire logic             clk_sys,          // System clock, 100 MHz
  input  wire logic             resetn,           // Asynchronous reset, active low
  input  wire logic [7:0]       reg_addr,         // Register byte offset
  input  wire logic             reg_wr,           // Write strobe
  input  wire logic             reg_rd,           // Read strobe
  input  wire logic [7:0]       reg_wdata,        // Write data
  output logic      [7:0]       reg_rdata,        // Read data, valid after reg_rd
  output logic                  reg_hit_q,        // Last access hit a mapped offset
  input  wire logic             tx_on,            // Transmitter enable
  input  wire logic             rx_on,            // Receiver enable
  input  wire logic             single_wire_tx_direction, // Single wire drives line
  input  wire logic             break_detect_flag, // Break detected
  input  wire logic             rx_edge_flag,     // Receive pin active edge seen
  output logic                  break_irq,        // Break interrupt request
  output logic                  rx_edge_irq,      // Edge interrupt request
  output logic                  sample_tick,      // Oversampling tick
  output logic                  bit_tick,         // Bit-rate tick
  output logic                  baud_running,     // Generator active
  input  wire logic             tx_serial,        // Transmitter shifter output
  output logic                  rx_serial,        // Receiver shifter input
  input  wire logic             rxd_pin_in,       // Receive pin level
  output logic                  rxd_pin_used,     // Receive pin owned by the port
  input  wire logic             txd_pin_in,       // Transmit pin level
  output logic                  txd_pin_out,      // Transmit pin drive value
  output logic                  txd_pin_oe,       // Transmit pin drive enable
  output link_mode_e            link_mode,        // Current routing mode
  output frame_cfg_s            frame_cfg,        // Frame format to the shifters
  input  wire logic [8:0]       tx_char_in,       // Character from transmit side
  input  wire logic             tx_char_load,     // Load strobe for tx_char_in
  output logic      [8:0]       tx_char_q,        // Character with parity inserted
  input  wire logic [8:0]       rx_char_in,       // Character from receive side
  input  wire logic             rx_char_valid,    // Strobe for rx_char_in
  output logic                  rx_parity_err_q   // Parity error of last character
);

  logic [7:0]           div_high_buf_q;
  logic [DIV_HIGH_W-1:0] div_high_work_q;
  logic [7:0]           div_low_q;
  logic [7:0]           frame_ctrl_q;
  logic                 baud_armed_q;
  logic [DIVISOR_W-1:0] baud_divisor;
  logic                 wr_high;
  logic                 wr_low;
  logic                 wr_frame;
  logic                 loop_sel;
  logic                 receive_source_select_sel;
  logic                 nine_sel;
  logic                 par_on;
  logic                 par_odd;
  logic                 tx_par;
  logic                 rx_ones;

  assign wr_high  = reg_wr && (reg_addr == OFS_DIV_HIGH);
  assign wr_low   = reg_wr && (reg_addr == OFS_DIV_LOW);
  assign wr_frame = reg_wr && (reg_addr == OFS_FRAME_CTRL);

  // High half waits in a buffer until the low half arrives
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_high_buf_q <= DIV_HIGH_RESET;
    end else if (wr_high) begin
      div_high_buf_q <= reg_wdata & HI_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_high_work_q <= DIV_HIGH_RESET[DIV_HIGH_W-1:0];
      div_low_q       <= DIV_LOW_RESET;
    end else if (wr_low) begin
      div_high_work_q <= div_high_buf_q[DIV_HIGH_W-1:0];
      div_low_q       <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_ctrl_q <= FRAME_CTRL_RESET;
    end else if (wr_frame) begin
      frame_ctrl_q <= reg_wdata & FC_WRITE_MASK;
    end
  end

  // Arms once either direction is enabled, then stays armed
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      baud_armed_q <= 1'b0;
    end else if (tx_on || rx_on) begin
      baud_armed_q <= 1'b1;
    end
  end

  assign baud_divisor = {div_high_work_q, div_low_q};
  assign baud_running = baud_armed_q && (baud_divisor != '0);

  baud_tick_gen #(
    .DIV_W (DIVISOR_W),
    .OVS   (OVERSAMPLE)
  ) u_baud (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .enable      (baud_armed_q),
    .divisor     (baud_divisor),
    .sample_tick (sample_tick),
    .bit_tick    (bit_tick)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_hit_q <= 1'b0;
    end else if (reg_rd) begin
      reg_hit_q <= 1'b1;
      unique case (reg_addr)
        OFS_DIV_HIGH:   reg_rdata <= div_high_buf_q & HI_WRITE_MASK;
        OFS_DIV_LOW:    reg_rdata <= div_low_q;
        OFS_FRAME_CTRL: reg_rdata <= frame_ctrl_q;
        default: begin
          reg_rdata <= 8'h00;
          reg_hit_q <= 1'b0;
        end
      endcase
    end else if (reg_wr) begin
      reg_hit_q <= (reg_addr == OFS_DIV_HIGH) || (reg_addr == OFS_DIV_LOW) ||
                   (reg_addr == OFS_FRAME_CTRL);
    end
  end

  assign break_irq   = break_detect_flag && div_high_buf_q[HI_BREAK_IE_BIT];
  assign rx_edge_irq = rx_edge_flag && div_high_buf_q[HI_EDGE_IE_BIT];

  assign loop_sel = frame_ctrl_q[FC_LOOP_BIT];
  assign receive_source_select_sel = frame_ctrl_q[FC_RECEIVE_SOURCE_SELECT_BIT];
  assign nine_sel = frame_ctrl_q[FC_NINE_BIT];
  assign par_on   = frame_ctrl_q[FC_PAR_ON_BIT];
  assign par_odd  = frame_ctrl_q[FC_PAR_ODD_BIT];

  always_comb begin
    if (!loop_sel) begin
      link_mode = LINK_NORMAL;
    end else if (!receive_source_select_sel) begin
      link_mode = LINK_LOOPBACK;
    end else begin
      link_mode = LINK_SINGLE_WIRE;
    end
  end

  always_comb begin
    unique case (link_mode)
      LINK_NORMAL: begin
        rx_serial   = rxd_pin_in;
        txd_pin_oe  = tx_on;
      end
      LINK_LOOPBACK: begin
        rx_serial   = tx_serial;
        txd_pin_oe  = tx_on;
      end
      LINK_SINGLE_WIRE: begin
        rx_serial   = (tx_on && single_wire_tx_direction) ? tx_serial
                                                          : txd_pin_in;
        txd_pin_oe  = tx_on && single_wire_tx_direction;
      end
      default: begin
        rx_serial   = 1'b1;
        txd_pin_oe  = 1'b0;
      end
    endcase
  end

  assign txd_pin_out  = tx_serial;
  assign rxd_pin_used = rx_on && !loop_sel;

  always_comb begin
    frame_cfg.nine_bit_frame        = nine_sel;
    frame_cfg.idle_count_after_stop = frame_ctrl_q[FC_IDLE_BIT];
    frame_cfg.parity_on             = par_on;
    frame_cfg.parity_odd_select     = par_odd;
    frame_cfg.frame_bits            = nine_sel ? FRAME_BITS_NINE : FRAME_BITS_EIGHT;
  end

  // Parity bit makes the total count of ones even, or odd when selected
  assign tx_par  = nine_sel ? ((^tx_char_in[7:0]) ^ par_odd)
                            : ((^tx_char_in[6:0]) ^ par_odd);
  assign rx_ones = nine_sel ? (^rx_char_in[8:0]) : (^rx_char_in[7:0]);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_char_q <= 9'h000;
    end else if (tx_char_load) begin
      tx_char_q <= tx_char_in;
      if (par_on && nine_sel) begin
        tx_char_q[8] <= tx_par;
      end else if (par_on) begin
        tx_char_q[7] <= tx_par;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_parity_err_q <= 1'b0;
    end else if (rx_char_valid) begin
      rx_parity_err_q <= par_on && (rx_ones != par_odd);
    end
  end

endmodule : baud_frame_config

//--- verification/baud_frame_config_asserts.sv
/*
  Port checker for baud_frame_config: shadows the registers from the writes.
  Assumes binding into the one-clock top module.
*/
`timescale 1ns/1ns
module baud_frame_config_asserts
  import baud_frame_pkg::*;
(
  input wire logic       clk_sys,                  // Clock
  input wire logic       resetn,                   // Reset
  input wire logic [7:0] reg_addr,                 // Offset
  input wire logic       reg_wr,                   // Write
  input wire logic [7:0] reg_wdata,                // Data
  input wire logic       tx_on,                    // Tx on
  input wire logic       rx_on,                    // Rx on
  input wire logic       single_wire_tx_direction, // Drive
  input wire logic       break_detect_flag,        // Flag
  input wire logic       rx_edge_flag,             // Flag
  input wire logic       break_irq,                // Request
  input wire logic       rx_edge_irq,              // Request
  input wire logic       sample_tick,              // Tick
  input wire logic       bit_tick,                 // Tick
  input wire logic       baud_running,             // Active
  input wire logic       tx_serial,                // Shifter out
  input wire logic       rx_serial,                // Shifter in
  input wire logic       rxd_pin_in,               // Pin
  input wire logic       rxd_pin_used,             // Owned
  input wire logic       txd_pin_in,               // Pin
  input wire logic       txd_pin_oe,               // Enable
  input wire link_mode_e link_mode,                // Mode
  input wire frame_cfg_s frame_cfg                 // Format
);
  logic [7:0]  hi_q, lo_q, fc_q;
  logic [4:0]  wh_q;
  logic [12:0] cnt_q;
  logic        arm_q, ok_q, wr_q;
  wire  [12:0] dv = {wh_q, lo_q};
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {hi_q, lo_q, fc_q} <= {DIV_HIGH_RESET, DIV_LOW_RESET, FRAME_CTRL_RESET};
      {wh_q, arm_q, ok_q, wr_q, cnt_q} <= '0;
    end else begin
      arm_q <= arm_q || tx_on || rx_on;
      wr_q <= reg_wr;
      // A tick left over from the old divisor must not start a measured period
      ok_q <= !reg_wr && !wr_q && baud_running && (ok_q || sample_tick);
      cnt_q <= (sample_tick || reg_wr) ? 13'h0001 : cnt_q + 13'h0001;
      if (reg_wr && reg_addr == OFS_DIV_HIGH) hi_q <= reg_wdata & HI_WRITE_MASK;
      if (reg_wr && reg_addr == OFS_DIV_LOW) begin
        lo_q <= reg_wdata;
        wh_q <= hi_q[4:0];
      end
      if (reg_wr && reg_addr == OFS_FRAME_CTRL) fc_q <= reg_wdata & FC_WRITE_MASK;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_break; break_irq == (break_detect_flag && hi_q[7]); endproperty
  a_break: assert property (p_break) else $error("break request wrong");
  property p_edge; rx_edge_irq == (rx_edge_flag && hi_q[6]); endproperty
  a_edge: assert property (p_edge) else $error("edge request wrong");
  property p_run; baud_running == (arm_q && dv != 13'h0000); endproperty
  a_run: assert property (p_run) else $error("generator state wrong");
  property p_quiet; !baud_running [*2] |-> !sample_tick && !bit_tick; endproperty
  a_quiet: assert property (p_quiet) else $error("tick while stopped");
  property p_period; sample_tick && ok_q |-> cnt_q == dv; endproperty
  a_period: assert property (p_period) else $error("tick period wrong");
  property p_bit; bit_tick |-> sample_tick; endproperty
  a_bit: assert property (p_bit) else $error("bit tick off grid");
  property p_mode;
    link_mode == (!fc_q[7] ? LINK_NORMAL : fc_q[5] ? LINK_SINGLE_WIRE : LINK_LOOPBACK);
  endproperty
  a_mode: assert property (p_mode) else $error("link mode wrong");
  property p_norm;
    link_mode == LINK_NORMAL |-> rx_serial == rxd_pin_in && txd_pin_oe == tx_on
      && rxd_pin_used == rx_on;
  endproperty
  a_norm: assert property (p_norm) else $error("normal routing wrong");
  property p_loop; link_mode == LINK_LOOPBACK |-> rx_serial == tx_serial && !rxd_pin_used;
  endproperty
  a_loop: assert property (p_loop) else $error("loop routing wrong");
  property p_single;
    link_mode == LINK_SINGLE_WIRE |-> txd_pin_oe == (tx_on && single_wire_tx_direction)
      && rx_serial == (txd_pin_oe ? tx_serial : txd_pin_in);
  endproperty
  a_single: assert property (p_single) else $error("single wire routing wrong");
  property p_frame; frame_cfg == {fc_q[4], fc_q[2], fc_q[1:0], 3'h5, fc_q[4]}; endproperty
  a_frame: assert property (p_frame) else $error("frame format wrong");
  c_fast: cover property (sample_tick [*3]);
  c_single: cover property (link_mode == LINK_SINGLE_WIRE && txd_pin_oe);
  c_break: cover property (break_irq);
endmodule : baud_frame_config_asserts

bind baud_frame_config baud_frame_config_asserts u_asserts (.*);

//--- verification/serial_node_model.sv
/*
  Remote serial node behind the bus transceiver.
  Assumes the bench sets the level the node sends; a one releases the line.
*/
`timescale 1ns/1ns
module serial_node_model (
  input  wire logic txd_pin_out, // Port drive value
  input  wire logic txd_pin_oe,  // Port drive enable
  input  wire logic node_bit,    // Level the node sends
  output logic      rxd_pin_in,  // Port receive pin
  output logic      txd_pin_in   // Shared line level
);
  assign rxd_pin_in = node_bit;
  // Pull-up shows high once both sides release the shared line
  assign txd_pin_in = txd_pin_oe ? txd_pin_out : node_bit;
endmodule : serial_node_model

//--- verification/baud_frame_config_tb.sv
/*
  Self-checking bench for baud_frame_config over its register port.
  Assumes the package, node model and checker are compiled first.
*/
`timescale 1ns/1ns
module baud_frame_config_tb;
  import baud_frame_pkg::*;
  logic       clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, tx_on = 0, rx_on = 0;
  logic       single_wire_tx_direction = 0, break_detect_flag = 0, rx_edge_flag = 0;
  logic       tx_serial = 0, tx_char_load = 0, rx_char_valid = 0, node_bit = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [8:0] tx_char_in = 9'h000, rx_char_in = 9'h000, tx_char_q;
  logic       reg_hit_q, break_irq, rx_edge_irq, sample_tick, bit_tick, baud_running;
  logic       rx_serial, rxd_pin_in, rxd_pin_used, txd_pin_in, txd_pin_out, txd_pin_oe;
  logic       rx_parity_err_q;
  link_mode_e link_mode;
  frame_cfg_s frame_cfg;
  int         num_errors = 0, check_count = 0;
  logic [7:0] fcv [6] = '{8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'hFF};
  logic [7:0] lnk [4] = '{8'h00, 8'h20, 8'h80, 8'hA0};
  always #5 clk_sys = ~clk_sys;
  baud_frame_config uut (.*);
  serial_node_model u_node (.*);
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp, logic hit);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check("reg_rdata", 16'(exp), 16'(reg_rdata));
    check("reg_hit_q", 16'(hit), 16'(reg_hit_q));
  endtask : rd
  task automatic ticks(int n, output int s, output int b);
    s = 0;
    b = 0;
    repeat (n) begin
      @(negedge clk_sys);
      s += int'(sample_tick === 1'b1);
      b += int'(bit_tick === 1'b1);
    end
  endtask : ticks
  // Cycles to the next sample tick; a missing tick ends the run
  task automatic wait_tick(int lim, int exp);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (sample_tick !== 1'b1 && n < lim);
    check("tick_gap", 16'(exp), 16'(n));
    if (sample_tick !== 1'b1) print_verdict();
  endtask : wait_tick
  initial begin
    int s, b;
    logic [8:0] e, m;
    logic r;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    rd(OFS_DIV_HIGH, 8'h00, 1'b1);
    rd(OFS_DIV_LOW, DIV_LOW_RESET, 1'b1);
    rd(OFS_FRAME_CTRL, 8'h00, 1'b1);
    rd(8'h43, 8'h00, 1'b0);
    ticks(40, s, b);
    check("idle_ticks", 16'(s + b + baud_running), 16'(0));
    rx_on = 1'b1;
    @(negedge clk_sys);
    rx_on = 1'b0;
    ticks(128, s, b);
    check("sample_count", 16'(32), 16'(s));
    check("bit_count", 16'(2), 16'(b));
    wr(OFS_DIV_HIGH, 8'hFF);
    rd(OFS_DIV_HIGH, 8'hDF, 1'b1);
    ticks(128, s, b);
    check("held_divisor", 16'(32), 16'(s));
    break_detect_flag = 1'b1;
    rx_edge_flag = 1'b1;
    #1 check("break_irq", 16'(1), 16'(break_irq));
    check("edge_irq", 16'(1), 16'(rx_edge_irq));
    wr(OFS_DIV_HIGH, 8'h01);
    check("break_off", 16'(0), 16'(break_irq));
    check("edge_off", 16'(0), 16'(rx_edge_irq));
    wr(OFS_DIV_LOW, 8'h00);
    wait_tick(400, 257);
    wait_tick(400, 256);
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_DIV_LOW, 8'h00);
    ticks(300, s, b);
    check("zero_divisor", 16'(s + b + baud_running), 16'(0));
    wr(OFS_DIV_LOW, 8'h01);
    wait_tick(10, 2);
    ticks(64, s, b);
    check("div1_samples", 16'(64), 16'(s));
    check("div1_bits", 16'(4), 16'(b));
    wr(OFS_DIV_HIGH, 8'h1F);
    wr(OFS_DIV_LOW, 8'hFF);
    wait_tick(9000, 8192);
    wait_tick(9000, 8191);
    foreach (fcv[i]) begin
      wr(OFS_FRAME_CTRL, fcv[i]);
      rd(OFS_FRAME_CTRL, fcv[i] & FC_WRITE_MASK, 1'b1);
      m = fcv[i][4] ? 9'h1FF : 9'h0FF;
      e = 9'h1A5;
      if (fcv[i][1]) e[fcv[i][4] ? 8 : 7] = ^(e & (m >> 1)) ^ fcv[i][0];
      tx_char_in = 9'h1A5;
      tx_char_load = 1'b1;
      rx_char_in = e ^ 9'h001;
      rx_char_valid = 1'b1;
      @(negedge clk_sys);
      tx_char_load = 1'b0;
      rx_char_in = e;
      check("tx_char_q", 16'(e & m), 16'(tx_char_q & m));
      check("parity_err", 16'(fcv[i][1]), 16'(rx_parity_err_q));
      check("frame_bits", 16'(fcv[i][4] ? 11 : 10), 16'(frame_cfg.frame_bits));
      @(negedge clk_sys);
      rx_char_valid = 1'b0;
      check("parity_ok", 16'(0), 16'(rx_parity_err_q));
    end
    tx_on = 1'b1;
    rx_on = 1'b1;
    foreach (lnk[i]) for (int d = 0; d < 2; d++) begin
      wr(OFS_FRAME_CTRL, lnk[i]);
      single_wire_tx_direction = d[0];
      tx_serial = d[0];
      node_bit = !d[0];
      r = (lnk[i][7] && !(lnk[i][5] && !d[0])) ? d[0] : !d[0];
      #1 check("rx_serial", 16'(r), 16'(rx_serial));
      check("rxd_pin_used", 16'(!lnk[i][7]), 16'(rxd_pin_used));
      check("txd_pin_out", 16'(d[0]), 16'(txd_pin_out));
      check("txd_pin_oe", 16'(!(lnk[i][7] && lnk[i][5]) || d[0]), 16'(txd_pin_oe));
    end
    print_verdict();
  end
endmodule : baud_frame_config_tb
